// File: core/nvbm_top.sv
`timescale 1ns/100ps
`default_nettype none
// Serial-bus byte memory target: 32K x 8 array behind two pins
module nvbm_top
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic [2:0] device_select_pins_i,
   input wire logic write_protect_i,
   output logic hs_mode_o,
   output logic busy_o
);
   import nvbm_pkg::*;

   typedef struct packed
   {
      logic scl_prev;
      logic sda_prev;
      nvbm_phase_t phase;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic in_ack;
      logic ack_drive;
      logic out_drive;
      logic [7:0] tx;
      logic [NVBM_AW-1:0] addr;
      logic [NVBM_AW-1:0] fetch;
      logic [6:0] addr_hi;
      logic hs;
      logic sel_rd;
      logic wr_en;
      logic [NVBM_AW-1:0] wr_addr;
      logic [7:0] wr_data;
      logic flush;
   } nvbm_state_t;

   nvbm_state_t s_q;
   nvbm_state_t s_d;
   logic [7:0] mem [NVBM_DEPTH];
   logic [7:0] rd_word;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic fill_valid;
   logic fill_ready;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_data;
   logic [7:0] rx_byte;
   logic fetch_ok;
   logic fetch_ok_q;
   logic tx_load;
   logic [3:0] pin_raw;
   logic [3:0] pin_s;

   // Target-address decode reused for the two cases it serves
   function automatic logic is_mine(input logic [7:0] b, input logic [2:0] pins);
      is_mine = (b[7:4] == NVBM_TYPE_CODE) && (b[3:1] == pins);
   endfunction

   function automatic logic is_hs_code(input logic [7:0] b);
      is_hs_code = (b[7:3] == NVBM_HS_CODE);
   endfunction

   // Pins from the controller's domain pass two flops first
   nvbm_sync u_sync_scl
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .en_i(clk_en_i),
      .d_i(scl_i),
      .q_o(scl_s)
   );
   nvbm_sync u_sync_sda
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .en_i(clk_en_i),
      .d_i(sda_i),
      .q_o(sda_s)
   );

   // Strap pins are asynchronous too; each passes its own two-flop synchroniser
   assign pin_raw = {write_protect_i, device_select_pins_i};
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_pin_sync
         nvbm_sync u_sync_pin
         (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .en_i(clk_en_i),
            .d_i(pin_raw[g]),
            .q_o(pin_s[g])
         );
      end
   endgenerate

   // Bus conditions seen from synchronised copies only
   assign scl_rise = scl_s && !s_q.scl_prev;
   assign scl_fall = !scl_s && s_q.scl_prev;
   assign start_c = scl_s && s_q.scl_prev && s_q.sda_prev && !sda_s;
   assign stop_c = scl_s && s_q.scl_prev && !s_q.sda_prev && sda_s;
   assign rx_byte = {s_q.shreg[6:0], sda_s};

   // Array: one write port, one read port, single cycle each
   always_ff @(posedge clock_i)
   begin
      if (clk_en_i && s_q.wr_en)
      begin
         mem[s_q.wr_addr] <= s_q.wr_data;
      end
      if (clk_en_i)
      begin
         rd_word <= mem[s_q.fetch];
      end
   end

   // Prefetch fills the buffer ahead of the bus; stalls when it is full
   // Prefetch opens at the read target byte so the first byte is ready
   assign fill_valid = ((s_q.phase == NVBM_RDATA)
      || (s_q.phase == NVBM_TARGET && s_q.in_ack && s_q.sel_rd)) && !s_q.flush;
   nvbm_skid u_skid
   (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .en_i(clk_en_i),
      .flush_i(s_q.flush),
      .in_valid_i(fill_valid && fetch_ok),
      .in_ready_o(fill_ready),
      .in_data_i(rd_word),
      .out_valid_o(tx_valid),
      .out_ready_i(tx_ready),
      .out_data_o(tx_data)
   );

   // Read data lags the fetch address by one cycle; track that
   assign fetch_ok = fetch_ok_q;
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         fetch_ok_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         fetch_ok_q <= fill_valid && !(fetch_ok_q && fill_ready);
      end
   end

   // Load a byte on the fall that closes an acknowledge slot, so its MSB
   // is on the line before the next rise
   assign tx_load = scl_fall && s_q.in_ack && !s_q.out_drive
      && ((s_q.phase == NVBM_TARGET && s_q.ack_drive && s_q.sel_rd)
      || (s_q.phase == NVBM_RDATA && !s_q.ack_drive));
   assign tx_ready = tx_load && tx_valid;

   // Protocol engine
   always_comb
   begin
      s_d = s_q;
      s_d.wr_en = 1'b0;
      s_d.flush = 1'b0;
      s_d.scl_prev = scl_s;
      s_d.sda_prev = sda_s;
      if (fetch_ok && fill_ready && fill_valid)
      begin
         s_d.fetch = NVBM_AW'(s_q.fetch + 1'b1);
      end
      if (start_c)
      begin
         // Repeated start aborts anything and readies the device
         s_d.phase = NVBM_TARGET;
         s_d.bitcnt = 3'h0;
         s_d.in_ack = 1'b0;
         s_d.ack_drive = 1'b0;
         s_d.out_drive = 1'b0;
         s_d.flush = 1'b1;
      end
      else if (stop_c)
      begin
         s_d.phase = NVBM_IDLE;
         s_d.hs = 1'b0;
         s_d.ack_drive = 1'b0;
         s_d.out_drive = 1'b0;
         s_d.in_ack = 1'b0;
         s_d.flush = 1'b1;
      end
      else if (scl_rise && s_q.phase != NVBM_IDLE)
      begin
         if (!s_q.in_ack)
         begin
            s_d.shreg = rx_byte;
            s_d.bitcnt = 3'(s_q.bitcnt + 1'b1);
            if (s_q.bitcnt == NVBM_BIT_LAST)
            begin
               s_d.in_ack = 1'b1;
               case (s_q.phase)
                  NVBM_TARGET:
                  begin
                     s_d.sel_rd = rx_byte[0];
                     if (is_hs_code(rx_byte))
                     begin
                        s_d.hs = 1'b1;
                        s_d.phase = NVBM_IDLE;
                     end
                     else if (!is_mine(rx_byte, pin_s[2:0]))
                     begin
                        s_d.phase = NVBM_IDLE;
                     end
                     else if (rx_byte[0])
                     begin
                        s_d.fetch = s_q.addr;
                     end
                  end
                  NVBM_ADDR_HI:
                  begin
                     s_d.addr_hi = rx_byte[6:0];
                  end
                  NVBM_ADDR_LO:
                  begin
                     s_d.addr = {s_q.addr_hi, rx_byte};
                  end
                  NVBM_WDATA:
                  begin
                     // Commit immediately; no busy period follows
                     s_d.wr_en = !pin_s[3];
                     s_d.wr_addr = s_q.addr;
                     s_d.wr_data = rx_byte;
                     s_d.addr = NVBM_AW'(s_q.addr + 1'b1);
                  end
                  NVBM_RDATA:
                  begin
                     s_d.addr = NVBM_AW'(s_q.addr + 1'b1);
                  end
                  default:
                  begin
                     s_d.phase = NVBM_IDLE;
                  end
               endcase
            end
         end
         else if (s_q.phase == NVBM_RDATA && !s_q.out_drive)
         begin
            // Controller's acknowledge bit decides whether to continue
            if (sda_s)
            begin
               s_d.phase = NVBM_IDLE;
               s_d.flush = 1'b1;
            end
         end
      end
      else if (scl_fall && s_q.phase != NVBM_IDLE)
      begin
         if (s_q.in_ack && !s_q.ack_drive && s_q.phase != NVBM_RDATA)
         begin
            s_d.ack_drive = 1'b1;
         end
         else if (s_q.in_ack && !s_q.ack_drive && !s_q.out_drive)
         begin
            // Master acknowledge slot over, next byte begins
            s_d.in_ack = 1'b0;
            s_d.bitcnt = 3'h0;
            s_d.tx = tx_data;
            s_d.out_drive = 1'b1;
         end
         else if (s_q.ack_drive)
         begin
            s_d.ack_drive = 1'b0;
            s_d.in_ack = 1'b0;
            s_d.bitcnt = 3'h0;
            case (s_q.phase)
               NVBM_TARGET:
               begin
                  if (s_q.sel_rd)
                  begin
                     s_d.phase = NVBM_RDATA;
                     s_d.tx = tx_data;
                     s_d.out_drive = 1'b1;
                  end
                  else
                  begin
                     s_d.phase = NVBM_ADDR_HI;
                  end
               end
               NVBM_ADDR_HI: s_d.phase = NVBM_ADDR_LO;
               NVBM_ADDR_LO: s_d.phase = NVBM_WDATA;
               default: s_d.phase = s_q.phase;
            endcase
         end
         if (s_q.phase == NVBM_RDATA && !s_q.in_ack)
         begin
            // Shift the outgoing byte MSB first after each fall
            s_d.tx = {s_q.tx[6:0], 1'b0};
         end
      end
      if (s_q.phase == NVBM_RDATA && s_q.in_ack && s_q.out_drive && scl_fall)
      begin
         s_d.out_drive = 1'b0; // Release for the controller's acknowledge
      end
      if (!nrst_i)
      begin
         s_d.phase = NVBM_IDLE;
         s_d.bitcnt = 3'h0;
         s_d.shreg = 8'h00;
         s_d.in_ack = 1'b0;
         s_d.ack_drive = 1'b0;
         s_d.out_drive = 1'b0;
         s_d.tx = 8'h00;
         s_d.addr = NVBM_ADDR_RST;
         s_d.fetch = NVBM_ADDR_RST;
         s_d.addr_hi = 7'h00;
         s_d.hs = 1'b0;
         s_d.sel_rd = 1'b0;
         s_d.wr_en = 1'b0;
         s_d.wr_addr = NVBM_ADDR_RST;
         s_d.wr_data = 8'h00;
         s_d.flush = 1'b1;
         s_d.scl_prev = 1'b1;
         s_d.sda_prev = 1'b1;
      end
      else if (!clk_en_i)
      begin
         s_d = s_q;
      end
   end

   always_ff @(posedge clock_i)
   begin
      s_q <= s_d;
   end

   // Open drain: drive low only, enable active low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !(s_q.ack_drive || (s_q.out_drive && !s_q.tx[7]));
   assign hs_mode_o = s_q.hs;
   assign busy_o = (s_q.phase != NVBM_IDLE);
endmodule
`default_nettype wire

// File: core/nvbm_pkg.sv
package nvbm_pkg;
   localparam int unsigned NVBM_DEPTH = 32768;
   localparam int unsigned NVBM_AW = 15;
   localparam logic [3:0] NVBM_TYPE_CODE = 4'hA;
   localparam logic [4:0] NVBM_HS_CODE = 5'h01;
   localparam logic [2:0] NVBM_BIT_LAST = 3'h7;
   localparam logic [NVBM_AW-1:0] NVBM_ADDR_RST = 15'h0000;
   // Identification bytes; values are arbitrary
   localparam logic [7:0] NVBM_ID_MAKER = 8'h5A;
   localparam logic [7:0] NVBM_ID_DENSITY = 8'h22;
   localparam logic [7:0] NVBM_ID_REV = 8'h01;
   typedef enum logic [2:0] {
      NVBM_IDLE,
      NVBM_TARGET,
      NVBM_ADDR_HI,
      NVBM_ADDR_LO,
      NVBM_WDATA,
      NVBM_RDATA
   } nvbm_phase_t;
endpackage

// File: core/nvbm_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for the bus pins
module nvbm_sync
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed
   {
      logic meta;
      logic sync;
   } nvbm_sync_t;
   nvbm_sync_t s_q;
   nvbm_sync_t s_d;

   // Idle bus level is high, so reset to one
   always_comb
   begin
      s_d = s_q;
      if (!nrst_i)
      begin
         s_d.meta = 1'b1;
         s_d.sync = 1'b1;
      end
      else if (en_i)
      begin
         s_d.meta = d_i;
         s_d.sync = s_q.meta;
      end
   end

   always_ff @(posedge clock_i)
   begin
      s_q <= s_d;
   end

   assign q_o = s_q.sync;
endmodule
`default_nettype wire

// File: core/nvbm_skid.sv
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer for outgoing read bytes
module nvbm_skid
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   typedef struct packed
   {
      logic [1:0][7:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
   } nvbm_skid_t;
   nvbm_skid_t b_q;
   nvbm_skid_t b_d;
   logic push;
   logic pop;

   assign in_ready_o = (b_q.cnt != 2'h2);
   assign out_valid_o = (b_q.cnt != 2'h0);
   assign out_data_o = b_q.mem[b_q.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Flush drops prefetched bytes when a read ends
   always_comb
   begin
      b_d = b_q;
      if (!nrst_i || flush_i)
      begin
         b_d.rd = 1'b0;
         b_d.wr = 1'b0;
         b_d.cnt = 2'h0;
      end
      else if (en_i)
      begin
         if (push)
         begin
            b_d.mem[b_q.wr] = in_data_i;
            b_d.wr = ~b_q.wr;
         end
         if (pop)
         begin
            b_d.rd = ~b_q.rd;
         end
         b_d.cnt = 2'(b_q.cnt + {1'b0, push} - {1'b0, pop});
      end
   end

   always_ff @(posedge clock_i)
   begin
      b_q <= b_d;
   end
endmodule
`default_nettype wire

// File: dv/nvbm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the serial memory target
module nvbm_chk
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic [2:0] device_select_pins_i,
   input wire logic write_protect_i,
   input wire logic hs_mode_o,
   input wire logic busy_o
);
   default clocking dc @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   // Open drain: the data pin value is never a driven high
   odrain_a: assert property (!sda_o) else $error("data pin driven high");
   // Target output only moves while the serial clock is low
   hold_a:
      assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
      else $error("data moved with clock high");
   // Outside a transaction the line is left alone
   idle_a: assert property (!busy_o |-> sda_oe_n_o) else $error("drive while idle");
   start_busy_a:
      assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] busy_o)
      else $error("start not taken");
   stop_idle_a:
      assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] !busy_o)
      else $error("stop left target busy");
   stop_hs_a:
      assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] !hs_mode_o)
      else $error("stop kept fast mode");
   // Master code is never acknowledged
   hs_noack_a:
      assert property ($rose(hs_mode_o) |-> sda_oe_n_o [*8])
      else $error("master code acked");
   hs_fall_a:
      assert property ($fell(hs_mode_o) |-> scl_i)
      else $error("fast mode left without stop");
endmodule
bind nvbm_top nvbm_chk nvbm_chk_inst
(
   .clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .device_select_pins_i(device_select_pins_i),
   .write_protect_i(write_protect_i), .hs_mode_o(hs_mode_o), .busy_o(busy_o)
);
`default_nettype wire

// File: dv/nvbm_ctl.sv
`timescale 1ns/100ps
`default_nettype none
// Bus controller model: makes the clock, pulls data low or releases it
module nvbm_ctl
(
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Low time per bit; raised by the bench to stall the target
   int lo_wait = 2;
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Data moves only with clock low; sampled late in the high phase
   task automatic bit_cell(input logic b, output logic r);
      sda_o <= b;
      tick(lo_wait);
      scl_o <= 1'b1;
      tick(3);
      @(negedge clock_i);
      r = sda_i;
      @(posedge clock_i);
      scl_o <= 1'b0;
      tick(2);
   endtask
   // Start, also as a repeated start from clock low
   task automatic start();
      sda_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b0;
      tick(2);
   endtask
   // Stop; the clock then stands high between frames
   task automatic stop();
      sda_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b1;
      tick(8);
   endtask
   // Byte out, MSB first; ninth bit released for the ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_cell(d[i], r);
      bit_cell(1'b1, r);
      ack = !r;
   endtask
   // Byte in; a missing ack ends the read
   task automatic rbyte(output logic [7:0] d, input logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_cell(1'b1, d[i]);
      bit_cell(!ack, r);
   endtask
endmodule
`default_nettype wire

// File: dv/nvbm_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the serial memory target
module nvbm_tb;
   import nvbm_pkg::*;
   localparam int CEIL = 20000;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic [2:0] pins = 3'h5;
   logic wp = 1'b0;
   wire scl;
   wire sda_m;
   wire sda_o;
   wire sda_oe_n;
   wire hs;
   wire busy;
   wire sda_line;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   logic ack;
   logic [7:0] d;
   // Wired-AND with pull-up: a released line reads high
   assign sda_line = sda_m & (sda_oe_n | sda_o);
   nvbm_top nvbm_top_inst
   (
      .clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .device_select_pins_i(pins),
      .write_protect_i(wp), .hs_mode_o(hs), .busy_o(busy)
   );
   nvbm_ctl nvbm_ctl_inst
   (
      .clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_m)
   );
   initial
   begin
      forever #50 clock_i = ~clock_i;
   end
   // Cycle ceiling cuts a hang short
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      if (cycles == CEIL)
      begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   // Start, own write target, two address bytes
   task automatic go_addr(input logic [15:0] a);
      nvbm_ctl_inst.start();
      nvbm_ctl_inst.wbyte({4'hA, pins, 1'b0}, ack);
      chk("target ack", 8'h01, {7'h0, ack});
      nvbm_ctl_inst.wbyte(a[15:8], ack);
      nvbm_ctl_inst.wbyte(a[7:0], ack);
      chk("addr ack", 8'h01, {7'h0, ack});
   endtask
   task automatic go_read();
      nvbm_ctl_inst.start();
      nvbm_ctl_inst.wbyte({4'hA, pins, 1'b1}, ack);
      chk("read ack", 8'h01, {7'h0, ack});
   endtask
   task automatic wr(input logic [7:0] v);
      nvbm_ctl_inst.wbyte(v, ack);
      chk("data ack", 8'h01, {7'h0, ack});
   endtask
   task automatic rd(input logic [7:0] exp, input logic more);
      nvbm_ctl_inst.rbyte(d, more);
      chk("read data", exp, d);
   endtask
   task automatic t_reset();
      chk("oe_n", 8'h01, {7'h0, sda_oe_n});
      chk("hs", 8'h00, {7'h0, hs});
      chk("busy", 8'h00, {7'h0, busy});
      $display("reset done");
   endtask
   // Bytes across the top of the array, read straight back, no polling
   task automatic t_wrap();
      go_addr(16'hFFFE);
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      nvbm_ctl_inst.stop();
      go_addr(16'h7FFE);
      go_read();
      rd(8'h11, 1'b1);
      rd(8'h22, 1'b1);
      rd(8'h33, 1'b0);
      nvbm_ctl_inst.stop();
      $display("wrap done");
   endtask
   // Every select pin setting against one target; foreign type ignored
   task automatic t_select();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clock_i);
         pins <= i[2:0];
         nvbm_ctl_inst.start();
         nvbm_ctl_inst.wbyte(8'hAA, ack);
         chk("select ack", {7'h0, i == 5}, {7'h0, ack});
         nvbm_ctl_inst.stop();
      end
      @(posedge clock_i);
      pins <= 3'h5;
      nvbm_ctl_inst.start();
      nvbm_ctl_inst.wbyte(8'hBA, ack);
      chk("type ack", 8'h00, {7'h0, ack});
      nvbm_ctl_inst.stop();
      $display("select done");
   endtask
   task automatic t_protect();
      go_addr(16'h0100);
      wr(8'hC3);
      nvbm_ctl_inst.stop();
      @(posedge clock_i);
      wp <= 1'b1;
      go_addr(16'h0100);
      wr(8'h3C);
      nvbm_ctl_inst.stop();
      @(posedge clock_i);
      wp <= 1'b0;
      go_addr(16'h0100);
      go_read();
      rd(8'hC3, 1'b0);
      nvbm_ctl_inst.stop();
      $display("protect done");
   endtask
   // All eight master codes: flag on, no ack, off at stop
   task automatic t_hs();
      for (int i = 0; i < 8; i++)
      begin
         nvbm_ctl_inst.start();
         nvbm_ctl_inst.wbyte({5'h01, i[2:0]}, ack);
         chk("code ack", 8'h00, {7'h0, ack});
         chk("hs on", 8'h01, {7'h0, hs});
         nvbm_ctl_inst.stop();
         chk("hs off", 8'h00, {7'h0, hs});
      end
      $display("hs done");
   endtask
   // Long clock low phases stall the read path; no byte may be lost
   task automatic t_stall();
      go_addr(16'h1234);
      wr(8'hA5);
      wr(8'h5A);
      wr(8'h0F);
      nvbm_ctl_inst.stop();
      nvbm_ctl_inst.lo_wait = 40;
      go_addr(16'h1234);
      go_read();
      chk("busy on", 8'h01, {7'h0, busy});
      rd(8'hA5, 1'b1);
      rd(8'h5A, 1'b1);
      rd(8'h0F, 1'b0);
      nvbm_ctl_inst.stop();
      nvbm_ctl_inst.lo_wait = 2;
      chk("busy off", 8'h00, {7'h0, busy});
      $display("stall done");
   endtask
   // Second reset: address back to zero, array contents kept
   task automatic t_rerst();
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      go_read();
      rd(8'h33, 1'b0);
      nvbm_ctl_inst.stop();
      $display("rerst done");
   endtask
   initial
   begin
      repeat (4) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      t_reset();
      t_wrap();
      t_select();
      t_protect();
      t_hs();
      t_stall();
      t_rerst();
      results();
   end
endmodule
`default_nettype wire
